// ==== rtl/tlcd_pkg.sv ====
// package for the triplexed display drive block: frame timing, slot
// encodings and the reading carrier.
// assumes one converter oscillator clock drives every user of it.
package tlcd_pkg;
    // oscillator cycles per backplane frame
    localparam int unsigned FRAME_DIV = 1200;
    // three backplanes, each owns one slot of the frame
    localparam int unsigned NUM_BP = 3;
    // each slot is split into a drive half and an inverted half (dc free)
    localparam int unsigned HALF_SLOTS = 2 * NUM_BP;
    localparam int unsigned HALF_LEN = FRAME_DIV / HALF_SLOTS;
    localparam int unsigned HALF_W = $clog2(HALF_LEN);
    // latch/hold low window at the end of each conversion
    localparam int unsigned HOLD_LOW_CYCLES = 100;
    // conversion length in oscillator cycles (counter model of sequence)
    localparam int unsigned CONV_CYCLES = 10000;
    localparam int unsigned CONV_W = $clog2(CONV_CYCLES);
    // segment drive lines and panel positions over all lines (three per line)
    localparam int unsigned NUM_SEG_LINES = 12;
    localparam int unsigned NUM_POS = NUM_SEG_LINES * NUM_BP;
    localparam logic [2:0] SLOT_RST = 3'h1;

    // one reading as it reaches the display: digit segments plus extras
    typedef struct packed {
        logic [27:0] digit_seg;
        logic [3:0] dp;
        logic minus;
        logic continuity;
        logic low_batt;
        logic spare;
    } tlcd_read_t;

    // backplane outputs travel together
    typedef struct packed {
        logic three;
        logic two;
        logic one;
    } tlcd_bp_t;
endpackage

// ==== rtl/tlcd_seg_line.sv ====
// one segment drive line: picks per slot from three position states.
// assumes slot and phase come from the frame timer of the top module.
`timescale 1ns/1ps
`default_nettype none
module tlcd_seg_line (
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire logic [2:0] slot_i,
    input wire logic phase_i,
    input wire logic [2:0] pos_on_i,
    output logic seg_o
);
    wire logic sel_on;
    wire logic next_seg;
    // backplane is ~phase in its slot: on takes phase, off follows plane
    assign sel_on = |(slot_i & pos_on_i);
    assign next_seg = sel_on ? phase_i : ~phase_i;
    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            seg_o <= 1'b0;
        else
            seg_o <= next_seg;
    end
endmodule
`default_nettype wire

// ==== rtl/tlcd_drive.sv ====
// triplexed display drive: frame timer, backplanes, segment lines,
// annunciator drive and the display latch with its latch/hold pin.
// assumes levels are binary; analog drive levels are built outside.
`timescale 1ns/1ps
`default_nettype none
module tlcd_drive #(
    parameter int unsigned FRAME_DIV = tlcd_pkg::FRAME_DIV,
    parameter int unsigned CONV_CYCLES = tlcd_pkg::CONV_CYCLES
) (
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire tlcd_pkg::tlcd_read_t result_i,
    input wire tlcd_pkg::tlcd_read_t live_i,
    input wire logic hold_pin_i,
    input wire logic cont_pin_i,
    input wire logic low_batt_i,
    output logic hold_pin_o,
    output logic hold_pin_oe_o,
    output tlcd_pkg::tlcd_bp_t bp_o,
    output logic [tlcd_pkg::NUM_SEG_LINES-1:0] seg_line_o,
    output logic annunc_o
);
    localparam int unsigned HALF_LEN = FRAME_DIV / tlcd_pkg::HALF_SLOTS;
    localparam int unsigned HALF_W = $clog2(HALF_LEN);
    localparam int unsigned CONV_W = $clog2(CONV_CYCLES);
    localparam logic [HALF_W-1:0] HALF_LAST = HALF_W'(HALF_LEN - 1);
    localparam logic [CONV_W-1:0] CONV_LAST = CONV_W'(CONV_CYCLES - 1);
    localparam logic [CONV_W-1:0] HOLD_START =
        CONV_W'(CONV_CYCLES - tlcd_pkg::HOLD_LOW_CYCLES);

    // the slot split needs six equal halves of at least two clocks
    if (FRAME_DIV % tlcd_pkg::HALF_SLOTS != 0 || FRAME_DIV < 12)
    begin : g_bad_frame
        $error("frame divide must be a multiple of six, at least 12");
    end

    if (CONV_CYCLES <= tlcd_pkg::HOLD_LOW_CYCLES)
    begin : g_bad_conv
        $error("conversion shorter than latch window");
    end

    // the slot rotation below is written for exactly three planes
    if (tlcd_pkg::NUM_BP != 3)
    begin : g_bad_planes
        $error("slot rotation serves three backplanes only");
    end

    // reading width must equal the position count; its three annunciator bits are replaced by pins and a tie-off
    if ($bits(tlcd_pkg::tlcd_read_t) != tlcd_pkg::NUM_POS)
    begin : g_bad_map
        $error("reading width differs from position count");
    end

    if ($countones(tlcd_pkg::SLOT_RST) != 1)
    begin : g_bad_slot
        $error("reset slot code must be one-hot");
    end

    // frame timer state
    logic [HALF_W-1:0] half_cnt;
    logic phase;
    logic [2:0] slot;

    wire logic half_end;
    wire logic slot_end;
    wire logic [HALF_W-1:0] next_half_cnt;
    wire logic next_phase;
    wire logic [2:0] next_slot;

    // frame = 3 slots x 2 halves, 200 clocks each at default
    assign half_end = (half_cnt == HALF_LAST);
    assign slot_end = half_end & phase;
    assign next_half_cnt = half_end ? '0 : half_cnt + 1'b1;
    assign next_phase = half_end ? ~phase : phase;
    // one-hot rotation: slot one, two, three, then one again
    assign next_slot = slot_end ? {slot[1:0], slot[2]} : slot;

    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            half_cnt <= '0;
        else
            half_cnt <= next_half_cnt;
    end

    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            phase <= 1'b0;
        else
            phase <= next_phase;
    end

    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            slot <= tlcd_pkg::SLOT_RST;
        else
            slot <= next_slot;
    end

    // backplane active in its slot: high first half, low second half
    wire logic next_bp_one;
    wire logic next_bp_two;
    wire logic next_bp_three;

    assign next_bp_one = next_slot[0] & ~next_phase;
    assign next_bp_two = next_slot[1] & ~next_phase;
    assign next_bp_three = next_slot[2] & ~next_phase;

    // reset shows slot one in its drive half, as the timer state does,
    // so no short first half appears after release
    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            bp_o <= tlcd_pkg::SLOT_RST;
        else
            bp_o <= {next_bp_three, next_bp_two, next_bp_one};
    end

    // high for the first half of the frame, low for the second: one
    // period per frame; plane three only drives while this is low, so a
    // segment tied here sees full drive and one tied to that plane none
    wire logic slot_two_drive;
    wire logic next_annunc;

    assign slot_two_drive = next_slot[1] & ~next_phase;
    assign next_annunc = next_slot[0] | slot_two_drive;

    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            annunc_o <= 1'b1;
        else
            annunc_o <= next_annunc;
    end

    // conversion sequence timer, drives the latch/hold pulse
    logic [CONV_W-1:0] conv_cnt;
    wire logic conv_end;
    wire logic [CONV_W-1:0] next_conv_cnt;

    assign conv_end = (conv_cnt == CONV_LAST);
    assign next_conv_cnt = conv_end ? '0 : conv_cnt + 1'b1;

    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            conv_cnt <= '0;
        else
            conv_cnt <= next_conv_cnt;
    end

    tlcd_pkg::tlcd_read_t shown;
    wire logic in_hold_window;
    wire logic pin_low;
    wire logic latch_now;
    wire logic pin_forced_low;
    wire tlcd_pkg::tlcd_read_t next_shown;

    assign in_hold_window = (conv_cnt >= HOLD_START);
    assign pin_low = ~hold_pin_i;
    // open-drain style: only ever pull low, outside party may force level
    assign hold_pin_o = 1'b0;
    assign hold_pin_oe_o = in_hold_window;
    // forced low outside our window means live counter display
    assign pin_forced_low = pin_low & ~in_hold_window;
    // a high pin during our window blocks the load and holds the reading
    assign latch_now = in_hold_window & pin_low;
    assign next_shown = pin_forced_low ? live_i :
        (latch_now ? result_i : shown);

    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            shown <= '0;
        else
            shown <= next_shown;
    end

    // continuity and low battery bypass the latch so they act at once
    wire logic [27:0] digit_on;
    wire logic [3:0] point_on;
    wire logic sign_on;
    wire logic [2:0] annunc_on;
    wire logic [tlcd_pkg::NUM_POS-1:0] pos_on;

    assign digit_on = shown.digit_seg;
    assign point_on = shown.dp;
    assign sign_on = shown.minus;
    // spare position tied off: nothing on the panel sits there
    assign annunc_on = {cont_pin_i, low_batt_i, 1'b0};
    assign pos_on = {digit_on, point_on, sign_on, annunc_on};

    genvar g;
    generate
        for (g = 0; g < tlcd_pkg::NUM_SEG_LINES; g++)
        begin : g_line
            wire logic [2:0] line_pos;

            assign line_pos = pos_on[3*g +: 3];

            tlcd_seg_line u_line (
                .mclk_i(mclk_i),
                .rst_b_i(rst_b_i),
                .slot_i(next_slot),
                .phase_i(next_phase),
                .pos_on_i(line_pos),
                .seg_o(seg_line_o[g])
            );
        end
    endgenerate
endmodule
`default_nettype wire

// ==== verification/tlcd_drive_properties.sv ====
// checker for the display drive, bound to its top module.
// assumes one clock; frame length a multiple of six.
`timescale 1ns/1ps
`default_nettype none
module tlcd_drive_properties #(
    parameter int unsigned FRAME_DIV = 12,
    parameter int unsigned CONV_CYCLES = 200
) (
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire logic cont_pin_i,
    input wire logic hold_pin_o,
    input wire logic hold_pin_oe_o,
    input wire tlcd_pkg::tlcd_bp_t bp_o,
    input wire logic [11:0] seg_line_o,
    input wire logic annunc_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);
    localparam int H = FRAME_DIV / 6;
    localparam int H3 = 3 * H;
    logic [7:0] run;
    always_ff @(posedge mclk_i or negedge rst_b_i)
        if (!rst_b_i)
            run <= 8'h0;
        else
            run <= hold_pin_oe_o ? run + 8'h1 : 8'h0;
    one_two_a: assert property (
        $fell(bp_o.one) |-> ##H $rose(bp_o.two)) else $error("slot two");
    two_three_a: assert property (
        $fell(bp_o.two) |-> ##H $rose(bp_o.three)) else $error("slot three");
    frame_wrap_a: assert property (
        $fell(bp_o.three) |-> ##H $rose(bp_o.one)) else $error("frame");
    drive_half_a: assert property (
        $rose(|bp_o) |-> ##H $fell(|bp_o)) else $error("half slot");
    annunc_half_a: assert property (
        $rose(annunc_o) |-> ##H3 $fell(annunc_o)) else $error("annunc");
    annunc_opp_a: assert property (
        bp_o.three |-> !annunc_o) else $error("annunc phase");
    bp_onehot_a: assert property (
        $onehot0(bp_o)) else $error("planes overlap");
    pin_low_a: assert property (
        hold_pin_oe_o |-> !hold_pin_o) else $error("pin level");
    hold_len_a: assert property (
        $fell(hold_pin_oe_o) |-> run == 8'(tlcd_pkg::HOLD_LOW_CYCLES))
        else $error("hold window");
    cont_seg_a: assert property (
        bp_o.three && $past(bp_o.three) && $stable(cont_pin_i)
        |-> seg_line_o[0] != cont_pin_i) else $error("continuity");
endmodule
bind tlcd_drive tlcd_drive_properties #(.FRAME_DIV(FRAME_DIV),
    .CONV_CYCLES(CONV_CYCLES)) props (.mclk_i, .rst_b_i, .cont_pin_i,
    .hold_pin_o, .hold_pin_oe_o, .bp_o, .seg_line_o, .annunc_o);
`default_nettype wire

// ==== verification/tlcd_panel.sv ====
// panel model: a position is lit when line and plane differ.
// assumes binary levels; only the driven half of a slot is read.
`timescale 1ns/1ps
`default_nettype none
module tlcd_panel (
    input wire logic mclk_i,
    input wire tlcd_pkg::tlcd_bp_t bp_i,
    input wire logic [11:0] seg_i,
    output logic [35:0] lit_o
);
    always @(posedge mclk_i)
        for (int g = 0; g < 12; g++)
            for (int s = 0; s < 3; s++)
                if (bp_i[s])
                    lit_o[3 * g + s] <= ~seg_i[g];
endmodule
`default_nettype wire

// ==== verification/tlcd_drive_tb.sv ====
// bench for the display drive: random readings through the latch.
// assumes short frame and conversion; the panel decodes the image.
`timescale 1ns/1ps
`default_nettype none
module tlcd_drive_tb;
    localparam int FD = 12;
    logic mclk_i = 0, rst_b_i = 0, cont_pin_i = 0, low_batt_i = 0;
    logic frc = 0, frc_val = 0, hold_pin_o, hold_pin_oe_o, annunc_o;
    tlcd_pkg::tlcd_read_t result_i = '0, live_i = '0, old;
    tlcd_pkg::tlcd_bp_t bp_o;
    logic [11:0] seg_line_o;
    logic [35:0] lit;
    int miscompares = 0, checks_done = 0, n;
    integer seed = 32'h9b4ed0f1;
    // pin floats high; an outside driver wins over the pull-down
    wire logic hold_pin_i = frc ? frc_val : !hold_pin_oe_o || hold_pin_o;
    always #2 mclk_i = ~mclk_i;
    tlcd_drive #(.FRAME_DIV(FD), .CONV_CYCLES(200)) dut (.mclk_i, .rst_b_i,
        .result_i, .live_i, .hold_pin_i, .cont_pin_i, .low_batt_i,
        .hold_pin_o, .hold_pin_oe_o, .bp_o, .seg_line_o, .annunc_o);
    tlcd_panel panel (.mclk_i, .bp_i(bp_o), .seg_i(seg_line_o), .lit_o(lit));
    function automatic logic [35:0] exp_img(tlcd_pkg::tlcd_read_t r);
        return {r[35:3], cont_pin_i, low_batt_i, 1'b0};
    endfunction
    task automatic close_out;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // one load window, then two frames so every slot is refreshed
    task automatic chk(logic [35:0] e);
        for (n = 0; n < 300 && !hold_pin_oe_o; n++)
            @(negedge mclk_i);
        for (; n < 300 && hold_pin_oe_o; n++)
            @(negedge mclk_i);
        repeat (2 * FD) @(negedge mclk_i);
        checks_done++;
        if (n >= 300 || lit !== e)
        begin
            miscompares++;
            $display("[ERR] %0t image %h expected %h", $time, lit, e);
            if (n >= 300)
                close_out();
        end
    endtask
    initial
    begin
        repeat (6) @(negedge mclk_i);
        rst_b_i = 1;
        for (int i = 0; i < 8; i++)
        begin
            result_i = i < 2 ? {36{i[0]}} :
                36'({$random(seed), $random(seed)});
            cont_pin_i = i[1];
            low_batt_i = i[2];
            chk(exp_img(result_i));
        end
        frc = 1;
        frc_val = 1;
        old = result_i;
        result_i = ~old;
        chk(exp_img(old));
        frc_val = 0;
        live_i = 36'({$random(seed), $random(seed)});
        chk(exp_img(live_i));
        close_out();
    end
endmodule
`default_nettype wire
